// *** svim_pkg.sv ***
// package: codes, offsets, defaults and types of the servo input function mapper
// How it works
// - control inputs 6 and 7 come from host image word +15, bits 5 and 6
// - host inputs 6 and 7 accept only code 0 and codes 14,17,19,20,29,32,57,58
// - fourteen functions sit at fixed, unchangeable bits of the host image
// - forced stop: host bit alone, or host bit OR open terminal contact
// - only inputs 1-5 are terminals; inputs 6-19 come from the host image
// - extended variant: codes 51-53 speed select, 43-47 override enable and weights
// - five always-on settings hold codes 0-76, default 0, adopted at power cycle
// - always-on function held from power-up: normally open on, except servo-on which follows its host bit; normally closed off
// - a function on a terminal and an always-on setting at once is accepted
// - deviation clear form: 0 edge, 1 level, default 0, adopted at power cycle
// - edge form clears deviation once per rising edge of deviation clear
// - each code from 1 to 76 selects exactly one function; code 0 selects none
// - power-cycle settings latch at power-up and are ignored until the next
package svim_pkg;
	localparam int NUM_FN   = 77;
	localparam int NUM_TERM = 5;
	localparam int NUM_SLOT = 19;
	localparam int NUM_AON  = 5;
	localparam int IMG_W    = 16;
	localparam int EXT_W    = 12;

	typedef logic [6:0] svim_code_t;
	typedef logic [NUM_FN-1:0] svim_fn_t;

	// function codes
	localparam svim_code_t CODE_NONE   = 7'h00;
	localparam svim_code_t FN_SERVO_ON = 7'h01;
	localparam svim_code_t FN_FWD      = 7'h02;
	localparam svim_code_t FN_POS_OT   = 7'h07;
	localparam svim_code_t FN_NEG_OT   = 7'h08;
	localparam svim_code_t FN_FSTOP    = 7'h0a;
	localparam svim_code_t FN_ACCEL_SELECT_BIT0     = 7'h0e;
	localparam svim_code_t FN_BRAKE_OH = 7'h22;
	localparam svim_code_t FN_OVR_EN   = 7'h2b;
	localparam svim_code_t FN_OVR_W1   = 7'h2c;
	localparam svim_code_t FN_INTR_IN  = 7'h31;
	localparam svim_code_t FN_DEVCLR   = 7'h32;
	localparam svim_code_t FN_SPD1     = 7'h33;
	localparam svim_code_t MAX_CODE    = 7'h4c;

	// host image: word offset in the image and the bits of control inputs 6 and 7
	localparam int IQ_WORD_OFS = 15;
	localparam int IQ_BIT_C6   = 5;
	localparam int IQ_BIT_C7   = 6;
	// fixed host image bits, bit 15 first; zero marks bits 5 and 6
	localparam logic [IMG_W-1:0][6:0] IQ_FIXED_CODE = {7'h4c, 7'h4b, 7'h36, 7'h32, 7'h30, 7'h26, 7'h25, 7'h10,
		7'h0b, 7'h00, 7'h00, 7'h0a, 7'h05, 7'h03, 7'h02, 7'h01};
	// normally closed functions
	localparam svim_fn_t NC_MASK = (77'h1 << FN_POS_OT) | (77'h1 << FN_NEG_OT) | (77'h1 << FN_FSTOP)
		| (77'h1 << FN_BRAKE_OH);

	// register byte offsets
	localparam logic [7:0] OFS_ASSIGN  = 8'h00;
	localparam logic [7:0] OFS_AON     = 8'h50;
	localparam logic [7:0] OFS_FORM    = 8'h64;
	localparam logic [7:0] OFS_IMG     = 8'h68;
	localparam logic [7:0] OFS_IMG_EXT = 8'h6c;
	localparam logic [7:0] OFS_STATUS  = 8'h70;
	localparam logic [7:0] OFS_LEVEL   = 8'h74;
	localparam int NUM_LVL_WORDS = 3;

	// status bit positions
	localparam int ST_SERVO  = 0;
	localparam int ST_FSTOP  = 1;
	localparam int ST_DEVCLR = 2;
	localparam int ST_FORM   = 3;
	localparam int ST_PEND   = 4;

	// reset values
	localparam svim_code_t ASSIGN1_DEF = 7'h31;
	localparam logic FORM_EDGE  = 1'b0;
	localparam logic FORM_LEVEL = 1'b1;

	typedef struct packed {
		logic [NUM_SLOT-1:0][6:0] slot_code;
		logic [NUM_AON-1:0][6:0]  aon_code;
		logic                     form_level;
	} svim_cfg_s;

	localparam svim_cfg_s CFG_DEF = '{slot_code: {{(NUM_SLOT-1){CODE_NONE}}, ASSIGN1_DEF},
		aon_code: '0, form_level: FORM_EDGE};

	// codes that host inputs 6 and 7 may carry
	function automatic logic host_code_ok(input svim_code_t c);
		case (c)
			7'h00, 7'h0e, 7'h11, 7'h13, 7'h14, 7'h1d, 7'h20, 7'h39, 7'h3a: host_code_ok = 1'b1;
			default: host_code_ok = 1'b0;
		endcase
	endfunction
endpackage

// *** svim_code_dec.sv ***
// one-hot decoder from a function code to the function vector
module svim_code_dec (
	// code in
	input  wire logic [6:0]                 code_i,
	// one bit per function
	output logic      [svim_pkg::NUM_FN-1:0] hit_o
);
	// code 0 and codes past the last function select nothing
	always_comb begin
		hit_o = '0;
		if (code_i != svim_pkg::CODE_NONE && code_i <= svim_pkg::MAX_CODE) begin
			hit_o[code_i] = 1'b1;
		end
	end
endmodule

// *** svim_devclr.sv ***
// deviation clear shaping: rising-edge pulse or level hold
module svim_devclr (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// form and request
	input  wire logic level_form_i,
	input  wire logic req_i,
	// clear command
	output logic      clr_o
);
	logic req_reg;

	// previous request level for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_reg <= 1'b0;
		end else begin
			req_reg <= req_i;
		end
	end

	// level form holds, edge form fires once per rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clr_o <= 1'b0;
		end else if (level_form_i) begin
			clr_o <= req_i;
		end else begin
			clr_o <= req_i & ~req_reg;
		end
	end

	a_edge_single: assert property (@(posedge clk_i) disable iff (rst_i)
		!level_form_i && clr_o |=> !clr_o) else $error("edge clear lasted more than one cycle");
	a_edge_rise: assert property (@(posedge clk_i) disable iff (rst_i)
		!level_form_i && req_i && !req_reg |=> clr_o) else $error("rising edge did not clear");
	a_level_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		level_form_i && req_i |=> clr_o) else $error("level clear not held");
endmodule

// *** svim_top.sv ***
// servo input function mapper: apb registers, source combining and function outputs
module svim_top #(
	parameter bit EXT_EN = 1'b1
) (
	// clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	// control power restore pulse: pending settings take effect
	input  wire logic        CTRL_PWR_CYCLE_I,
	// apb slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// control input terminals 1 to 5, high = contact closed
	input  wire logic [4:0]  TERM_IN_I,
	// function results
	output logic             SERVO_ON_O,
	output logic             FORCED_STOP_O,
	output logic             DEV_CLEAR_O,
	output logic      [2:0]  SPEED_SEL_O,
	output logic             OVERRIDE_EN_O,
	output logic      [3:0]  OVERRIDE_WEIGHT_O,
	output logic      [76:0] FUNC_LEVEL_O
);
	localparam int NS = svim_pkg::NUM_SLOT;
	localparam int NA = svim_pkg::NUM_AON;
	localparam int NT = svim_pkg::NUM_TERM;

	svim_pkg::svim_cfg_s pend_reg;
	svim_pkg::svim_cfg_s act_reg;
	logic [svim_pkg::IMG_W-1:0] img_reg;
	logic [svim_pkg::EXT_W-1:0] img_ext_reg;
	logic [NS-1:0]              slot_lvl;
	svim_pkg::svim_fn_t         slot_hit [NS];
	svim_pkg::svim_fn_t         aon_hit [NA];
	svim_pkg::svim_fn_t         term_on;
	svim_pkg::svim_fn_t         term_off;
	svim_pkg::svim_fn_t         host_on;
	svim_pkg::svim_fn_t         term_asg;
	svim_pkg::svim_fn_t         fn_next;
	logic                       servo_next;
	logic                       fstop_next;
	logic                       acc_phase;
	logic                       wr_en;
	logic                       mapped;
	logic                       bad_wr;
	logic [31:0]                rd_next;

	// byte address of word i above a base
	function automatic logic [7:0] word_addr(input logic [7:0] base, input int i);
		word_addr = base + 8'(i * 4);
	endfunction

	// address falls inside a block of n words
	function automatic logic in_block(input logic [7:0] a, input logic [7:0] base, input int n);
		in_block = (a >= base) && (a < word_addr(base, n)) && (a[1:0] == 2'b00);
	endfunction

	// zero-wait slave: every access ends in its first access cycle
	assign PREADY_O  = 1'b1;
	assign acc_phase = PSEL_I & PENABLE_I;
	assign wr_en     = acc_phase & PWRITE_I & ~bad_wr;

	// address decode and write checking
	always_comb begin
		mapped = in_block(PADDR_I, svim_pkg::OFS_ASSIGN, NS) || in_block(PADDR_I, svim_pkg::OFS_AON, NA)
			|| PADDR_I == svim_pkg::OFS_FORM || PADDR_I == svim_pkg::OFS_IMG
			|| PADDR_I == svim_pkg::OFS_IMG_EXT || PADDR_I == svim_pkg::OFS_STATUS
			|| in_block(PADDR_I, svim_pkg::OFS_LEVEL, svim_pkg::NUM_LVL_WORDS);
		bad_wr = ~mapped;
		if (PWRITE_I) begin
			// status and level words are read only
			if (PADDR_I == svim_pkg::OFS_STATUS
				|| in_block(PADDR_I, svim_pkg::OFS_LEVEL, svim_pkg::NUM_LVL_WORDS)) begin
				bad_wr = 1'b1;
			end
			// codes past the last function are refused
			if ((in_block(PADDR_I, svim_pkg::OFS_ASSIGN, NS) || in_block(PADDR_I, svim_pkg::OFS_AON, NA))
				&& PWDATA_I[6:0] > svim_pkg::MAX_CODE) begin
				bad_wr = 1'b1;
			end
			// host inputs 6 and 7 take only the selectable codes
			if ((PADDR_I == word_addr(svim_pkg::OFS_ASSIGN, svim_pkg::IQ_BIT_C6)
				|| PADDR_I == word_addr(svim_pkg::OFS_ASSIGN, svim_pkg::IQ_BIT_C7))
				&& !svim_pkg::host_code_ok(PWDATA_I[6:0])) begin
				bad_wr = 1'b1;
			end
		end
	end

	// errors are flagged in the access cycle only
	assign PSLVERR_O = acc_phase & bad_wr;

	// pending settings: software writes here, the block does not use them yet
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			pend_reg <= svim_pkg::CFG_DEF;
		end else if (wr_en) begin
			for (int s = 0; s < NS; s++) begin
				if (PADDR_I == word_addr(svim_pkg::OFS_ASSIGN, s)) begin
					pend_reg.slot_code[s] <= PWDATA_I[6:0];
				end
			end
			for (int a = 0; a < NA; a++) begin
				if (PADDR_I == word_addr(svim_pkg::OFS_AON, a)) begin
					pend_reg.aon_code[a] <= PWDATA_I[6:0];
				end
			end
			if (PADDR_I == svim_pkg::OFS_FORM) begin
				pend_reg.form_level <= PWDATA_I[0];
			end
		end
	end

	// active settings change only at power-up or a control power restore
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			act_reg <= svim_pkg::CFG_DEF;
		end else if (CTRL_PWR_CYCLE_I) begin
			act_reg <= pend_reg;
		end
	end

	// host input image, live as soon as written
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			img_reg     <= '0;
			img_ext_reg <= '0;
		end else if (wr_en && PADDR_I == svim_pkg::OFS_IMG) begin
			img_reg <= PWDATA_I[svim_pkg::IMG_W-1:0];
		end else if (wr_en && PADDR_I == svim_pkg::OFS_IMG_EXT) begin
			img_ext_reg <= PWDATA_I[svim_pkg::EXT_W-1:0];
		end
	end

	// signal source of each control input and its decoder
	generate
		for (genvar s = 0; s < NS; s++) begin : g_slot
			if (s < NT) begin : g_term
				assign slot_lvl[s] = TERM_IN_I[s];
			end else if (s == svim_pkg::IQ_BIT_C6) begin : g_c6
				assign slot_lvl[s] = img_reg[svim_pkg::IQ_BIT_C6];
			end else if (s == svim_pkg::IQ_BIT_C7) begin : g_c7
				assign slot_lvl[s] = img_reg[svim_pkg::IQ_BIT_C7];
			end else begin : g_ext
				// inputs 8 to 19 exist only in the extended variant
				assign slot_lvl[s] = EXT_EN & img_ext_reg[s - svim_pkg::IQ_BIT_C7 - 1];
			end
			svim_code_dec u_dec (
				.code_i (act_reg.slot_code[s]),
				.hit_o  (slot_hit[s])
			);
		end
		for (genvar a = 0; a < NA; a++) begin : g_aon
			svim_code_dec u_dec (
				.code_i (act_reg.aon_code[a]),
				.hit_o  (aon_hit[a])
			);
		end
	endgenerate

	// gather sources; duplicates on terminals and always-on simply merge
	always_comb begin
		term_on  = '0;
		term_off = '0;
		host_on  = '0;
		for (int s = 0; s < NS; s++) begin
			if (s < NT) begin
				term_on  = term_on | (slot_hit[s] & {svim_pkg::NUM_FN{slot_lvl[s]}});
				term_off = term_off | (slot_hit[s] & {svim_pkg::NUM_FN{~slot_lvl[s]}});
			end else begin
				host_on = host_on | (slot_hit[s] & {svim_pkg::NUM_FN{slot_lvl[s]}});
			end
		end
		for (int a = 0; a < NA; a++) begin
			term_on  = term_on | (aon_hit[a] & ~svim_pkg::NC_MASK);
			term_off = term_off | (aon_hit[a] & svim_pkg::NC_MASK);
		end
		for (int b = 0; b < svim_pkg::IMG_W; b++) begin
			if (svim_pkg::IQ_FIXED_CODE[b] != svim_pkg::CODE_NONE) begin
				host_on[svim_pkg::IQ_FIXED_CODE[b]] = host_on[svim_pkg::IQ_FIXED_CODE[b]] | img_reg[b];
			end
		end
	end

	assign term_asg = term_on | term_off;

	// servo-on and forced stop combine host and terminal in their own ways
	always_comb begin
		if (term_asg[svim_pkg::FN_SERVO_ON]) begin
			servo_next = host_on[svim_pkg::FN_SERVO_ON] & term_on[svim_pkg::FN_SERVO_ON]
				& ~term_off[svim_pkg::FN_SERVO_ON];
		end else begin
			servo_next = host_on[svim_pkg::FN_SERVO_ON];
		end
		fstop_next = host_on[svim_pkg::FN_FSTOP] | term_off[svim_pkg::FN_FSTOP];
	end

	// contact level per function: normally open ors sources except servo-on, normally closed opens on any terminal or always-on source
	always_comb begin
		fn_next = ((term_on | host_on) & ~svim_pkg::NC_MASK) | (~term_off & svim_pkg::NC_MASK);
		fn_next[svim_pkg::FN_SERVO_ON] = servo_next;
		fn_next[svim_pkg::FN_FSTOP]    = ~fstop_next;
		fn_next[svim_pkg::CODE_NONE]   = 1'b0;
	end

	// registered function results
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			FUNC_LEVEL_O  <= '0;
			SERVO_ON_O    <= 1'b0;
			FORCED_STOP_O <= 1'b0;
		end else begin
			FUNC_LEVEL_O  <= fn_next;
			SERVO_ON_O    <= servo_next;
			FORCED_STOP_O <= fstop_next;
		end
	end

	// multi-step speed and override bits; zero outside the extended variant
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			SPEED_SEL_O       <= '0;
			OVERRIDE_EN_O     <= 1'b0;
			OVERRIDE_WEIGHT_O <= '0;
		end else begin
			SPEED_SEL_O       <= EXT_EN ? fn_next[svim_pkg::FN_SPD1 +: 3] : 3'h0;
			OVERRIDE_EN_O     <= EXT_EN & fn_next[svim_pkg::FN_OVR_EN];
			OVERRIDE_WEIGHT_O <= EXT_EN ? fn_next[svim_pkg::FN_OVR_W1 +: 4] : 4'h0;
		end
	end

	// deviation clear shaping by the adopted form
	svim_devclr u_devclr (
		.clk_i        (CORE_CLK_I),
		.rst_i        (RST_I),
		.level_form_i (act_reg.form_level),
		.req_i        (fn_next[svim_pkg::FN_DEVCLR]),
		.clr_o        (DEV_CLEAR_O)
	);

	// read mux; reads show the pending settings, status shows what is in force
	always_comb begin
		rd_next = '0;
		for (int s = 0; s < NS; s++) begin
			if (PADDR_I == word_addr(svim_pkg::OFS_ASSIGN, s)) begin
				rd_next[6:0] = pend_reg.slot_code[s];
			end
		end
		for (int a = 0; a < NA; a++) begin
			if (PADDR_I == word_addr(svim_pkg::OFS_AON, a)) begin
				rd_next[6:0] = pend_reg.aon_code[a];
			end
		end
		for (int w = 0; w < svim_pkg::NUM_LVL_WORDS; w++) begin
			if (PADDR_I == word_addr(svim_pkg::OFS_LEVEL, w)) begin
				rd_next = 32'({3'h0, FUNC_LEVEL_O} >> (w * 32));
			end
		end
		if (PADDR_I == svim_pkg::OFS_FORM) begin
			rd_next[0] = pend_reg.form_level;
		end
		if (PADDR_I == svim_pkg::OFS_IMG) begin
			rd_next[svim_pkg::IMG_W-1:0] = img_reg;
		end
		if (PADDR_I == svim_pkg::OFS_IMG_EXT) begin
			rd_next[svim_pkg::EXT_W-1:0] = img_ext_reg;
		end
		if (PADDR_I == svim_pkg::OFS_STATUS) begin
			rd_next[svim_pkg::ST_SERVO]  = SERVO_ON_O;
			rd_next[svim_pkg::ST_FSTOP]  = FORCED_STOP_O;
			rd_next[svim_pkg::ST_DEVCLR] = DEV_CLEAR_O;
			rd_next[svim_pkg::ST_FORM]   = act_reg.form_level;
			rd_next[svim_pkg::ST_PEND]   = pend_reg != act_reg; // waiting for a power cycle
		end
	end

	// read data captured in the setup cycle so it stands through the access cycle
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			PRDATA_O <= '0;
		end else if (PSEL_I && !PENABLE_I) begin
			PRDATA_O <= rd_next;
		end
	end

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	a_servo_host_only: assert property (!term_asg[svim_pkg::FN_SERVO_ON]
		|=> SERVO_ON_O == $past(img_reg[0])) else $error("servo-on not following host bit");
	a_servo_and_term: assert property (term_asg[svim_pkg::FN_SERVO_ON] && !term_on[svim_pkg::FN_SERVO_ON]
		|=> !SERVO_ON_O) else $error("servo-on without terminal");
	a_fstop_either: assert property (term_off[svim_pkg::FN_FSTOP] || img_reg[4]
		|=> FORCED_STOP_O) else $error("forced stop missed");
	a_cont6_source: assert property (act_reg.slot_code[svim_pkg::IQ_BIT_C6] == svim_pkg::FN_ACCEL_SELECT_BIT0
		&& img_reg[svim_pkg::IQ_BIT_C6] |=> FUNC_LEVEL_O[svim_pkg::FN_ACCEL_SELECT_BIT0]) else $error("host input 6 lost");
	a_host_codes: assert property (svim_pkg::host_code_ok(pend_reg.slot_code[svim_pkg::IQ_BIT_C6])
		&& svim_pkg::host_code_ok(pend_reg.slot_code[svim_pkg::IQ_BIT_C7])) else $error("bad host input code");
	a_fixed_devclr: assert property (img_reg[12] |=> FUNC_LEVEL_O[svim_pkg::FN_DEVCLR])
		else $error("fixed host bit ignored");
	a_settings_held: assert property (!CTRL_PWR_CYCLE_I |=> act_reg == $past(act_reg))
		else $error("settings changed without power cycle");
	a_aon_no_on: assert property (act_reg.aon_code[0] == svim_pkg::FN_FWD
		|=> FUNC_LEVEL_O[svim_pkg::FN_FWD]) else $error("always-on function off");
	a_aon_nc_off: assert property (act_reg.aon_code[0] == svim_pkg::FN_POS_OT
		|=> !FUNC_LEVEL_O[svim_pkg::FN_POS_OT]) else $error("always-on closed contact not open");
	a_code0_none: assert property (!FUNC_LEVEL_O[0]) else $error("code 0 drove a function");

	c_servo_term: cover property (term_on[svim_pkg::FN_SERVO_ON] ##1 SERVO_ON_O);
	c_fstop_term: cover property (term_off[svim_pkg::FN_FSTOP] ##1 FORCED_STOP_O);
	c_dev_clear: cover property (DEV_CLEAR_O);
	c_power_cycle: cover property (CTRL_PWR_CYCLE_I && pend_reg != act_reg);
endmodule

// *** svim_host_model.sv ***
// host motion controller model: apb master that writes the input image and settings
module svim_host_model (
	// clock
	input  wire logic        clk_i,
	// apb master side
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [7:0]  paddr_o,
	output logic      [31:0] pwdata_o,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0000_0000;
	end

	// one transfer; image bits 5 and 6 of word +15 carry inputs 6 and 7
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= wd;
		@(posedge clk_i);
		penable_o <= 1'b1;
		@(posedge clk_i);
		// no assumed latency: only the bench watchdog ends a stuck wait
		while (pready_i !== 1'b1) begin
			@(posedge clk_i);
		end
		rd = prdata_i;
		err = pslverr_i;
		// a released bus shows the inverse, so a stale value cannot pass for held data
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~wd;
	endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the servo input function mapper
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, rst, pwr, psel, penable, pwrite, pready, pslverr;
	logic        servo, fstop, devclr, ovr_en;
	logic [4:0]  term;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0]  spd;
	logic [3:0]  ovr_w;
	logic [76:0] lvl;
	int          miscompares, num_checks;

	svim_top #(.EXT_EN(1'b1)) i_dut (.CORE_CLK_I(clk), .RST_I(rst), .CTRL_PWR_CYCLE_I(pwr),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.TERM_IN_I(term), .SERVO_ON_O(servo), .FORCED_STOP_O(fstop), .DEV_CLEAR_O(devclr),
		.SPEED_SEL_O(spd), .OVERRIDE_EN_O(ovr_en), .OVERRIDE_WEIGHT_O(ovr_w), .FUNC_LEVEL_O(lvl));

	svim_host_model i_host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr));

	// clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// compare tasks
	task automatic chk_bit(input logic got, input logic exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %b expected %b", $time, msg, got, exp);
		end
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// bus helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] rd;
		logic        err;
		i_host.xfer(1'b1, a, d, rd, err);
		chk_bit(err, exp_err, "write error flag");
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic        err;
		i_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
		chk_word(rd, exp, "read data");
	endtask

	// let outputs land one cycle after an input change
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// control power restore: pending settings become active
	task automatic pcycle();
		@(posedge clk);
		pwr <= 1'b1;
		@(posedge clk);
		pwr <= 1'b0;
		settle();
	endtask

	task automatic s_servo();
		wr(8'h68, 32'h1, 1'b0);
		settle();
		chk_bit(servo, 1'b1, "servo host only");
		wr(8'h04, 32'h1, 1'b0);
		pcycle();
		chk_bit(servo, 1'b0, "servo terminal open");
		// terminals change on the rising edge, like every other input
		@(posedge clk);
		term <= 5'h02;
		settle();
		chk_bit(servo, 1'b1, "servo both on");
		wr(8'h68, 32'h0, 1'b0);
		settle();
		chk_bit(servo, 1'b0, "servo host off");
	endtask

	task automatic s_fstop();
		wr(8'h68, 32'h10, 1'b0);
		settle();
		chk_bit(fstop, 1'b1, "stop host only");
		wr(8'h08, 32'h0a, 1'b0);
		pcycle();
		@(posedge clk);
		term <= 5'h06;
		wr(8'h68, 32'h0, 1'b0);
		settle();
		chk_bit(fstop, 1'b0, "stop contact closed");
		@(posedge clk);
		term <= 5'h02;
		settle();
		chk_bit(fstop, 1'b1, "stop contact open");
		@(posedge clk);
		term <= 5'h06;
		wr(8'h68, 32'h10, 1'b0);
		settle();
		chk_bit(fstop, 1'b1, "stop host with contact");
		wr(8'h68, 32'h0, 1'b0);
	endtask

	task automatic s_host_codes();
		logic [6:0] ok_codes [8] = '{7'h0e, 7'h11, 7'h13, 7'h14, 7'h1d, 7'h20, 7'h39, 7'h3a};
		foreach (ok_codes[i]) begin
			wr(8'h14, {25'h0, ok_codes[i]}, 1'b0);
			rd_chk(8'h14, {25'h0, ok_codes[i]});
		end
		wr(8'h14, 32'h0f, 1'b1);
		rd_chk(8'h14, 32'h3a);
		wr(8'h18, 32'h01, 1'b1);
		wr(8'h18, 32'h11, 1'b0);
		pcycle();
		wr(8'h68, 32'h60, 1'b0);
		settle();
		chk_word({30'h0, lvl[58], lvl[17]}, 32'h3, "inputs 6 and 7 on");
		wr(8'h68, 32'h20, 1'b0);
		settle();
		chk_word({30'h0, lvl[58], lvl[17]}, 32'h2, "input 6 only");
		wr(8'h68, 32'h0, 1'b0);
	endtask

	task automatic s_aon();
		rd_chk(8'h00, 32'h31);
		rd_chk(8'h50, 32'h0);
		wr(8'h80, 32'h1, 1'b1);
		rd_chk(8'h80, 32'h0);
		wr(8'h50, 32'h02, 1'b0);
		settle();
		chk_bit(lvl[2], 1'b0, "pending always-on");
		rd_chk(8'h70, 32'h10);
		pcycle();
		chk_bit(lvl[2], 1'b1, "always-on open contact");
		rd_chk(8'h74, 32'h0000_0584);
		wr(8'h54, 32'h07, 1'b0);
		wr(8'h58, 32'h4d, 1'b1);
		wr(8'h5c, 32'h4c, 1'b0);
		wr(8'h5c, 32'h0, 1'b0);
		wr(8'h0c, 32'h02, 1'b0);
		pcycle();
		chk_bit(lvl[7], 1'b0, "always-on closed contact");
		chk_bit(lvl[2], 1'b1, "terminal and always-on");
		chk_bit(lvl[0], 1'b0, "code zero");
	endtask

	task automatic s_devclr();
		logic [31:0] cnt;
		cnt = 32'h0;
		wr(8'h68, 32'h1000, 1'b0);
		repeat (8) begin
			@(posedge clk);
			#1;
			cnt = cnt + {31'h0, devclr};
		end
		chk_word(cnt, 32'h1, "edge form pulses");
		wr(8'h64, 32'h1, 1'b0);
		pcycle();
		cnt = 32'h0;
		repeat (5) begin
			@(posedge clk);
			#1;
			cnt = cnt + {31'h0, devclr};
		end
		chk_word(cnt, 32'h5, "level form hold");
		wr(8'h68, 32'h0, 1'b0);
		settle();
		chk_bit(devclr, 1'b0, "level form release");
	endtask

	task automatic s_ext();
		wr(8'h1c, 32'h33, 1'b0);
		wr(8'h20, 32'h34, 1'b0);
		wr(8'h24, 32'h35, 1'b0);
		wr(8'h28, 32'h2b, 1'b0);
		wr(8'h2c, 32'h2c, 1'b0);
		pcycle();
		wr(8'h6c, 32'h1f, 1'b0);
		settle();
		chk_word({24'h0, spd, ovr_en, ovr_w}, 32'hf1, "speed and override all");
		wr(8'h6c, 32'h02, 1'b0);
		settle();
		chk_word({24'h0, spd, ovr_en, ovr_w}, 32'h40, "speed bit 2 only");
		chk_word({29'h0, lvl[53:51]}, 32'h2, "one function per code");
		wr(8'h68, 32'h8000, 1'b0);
		settle();
		chk_word({30'h0, lvl[76:75]}, 32'h2, "fixed image bit");
	endtask

	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// watchdog cuts a hang short
	initial begin
		repeat (4000) @(posedge clk);
		miscompares++;
		stop_test();
	end

	// main sequence
	initial begin
		miscompares = 0;
		num_checks = 0;
		rst = 1'b1;
		pwr = 1'b0;
		term = 5'h00;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		s_aon();
		s_servo();
		s_fstop();
		s_host_codes();
		s_devclr();
		s_ext();
		stop_test();
	end
endmodule
